// file: dv/tb.sv
`timescale 1ns/1ps
// self-checking random bench for the per-port receiver interrupt status block
module tb;
	import rx_port_irq_pkg::*;
	logic                      i_sys_clk = 1'b0;
	logic                      i_reset = 1'b1;
	logic                      i_reg_wr = 1'b0;
	logic                      i_reg_rd = 1'b0;
	logic [7:0]                i_reg_addr = 8'h00;
	logic [7:0]                i_reg_wdata = 8'h00;
	logic                      i_status_one_rd = 1'b0;
	logic                      i_status_two_rd = 1'b0;
	logic [NUM_PORTS*8-1:0]    i_event_pulse = '0;
	logic [NUM_PORTS*4-1:0]    i_fwd_gpio = '0;
	logic [7:0]                o_reg_rdata;
	logic                      o_reg_rvalid;
	logic [NUM_PORTS-1:0]      o_port_irq;
	logic [7:0]                m_ev [NUM_PORTS];
	logic [7:0]                m_en [NUM_PORTS];
	logic [7:0]                m_gen [NUM_PORTS];
	logic [3:0]                m_gf [NUM_PORTS];
	logic [3:0]                m_prev [NUM_PORTS];
	logic [PORT_W-1:0]         m_sel;
	logic [7:0]                m_rdata;
	logic                      m_rv;
	logic [NUM_PORTS-1:0]      m_irq;
	logic [31:0]               seed = 32'd53310;
	logic [31:0]               r;
	int                        num_errors = 0;
	int                        total_checks = 0;
	logic [7:0] addr_tab [8] = '{ADDR_PORT_SELECT, ADDR_PORT_EVENT_ENABLE, ADDR_PORT_EVENT_STATUS,
		ADDR_GPIO_STATUS, ADDR_GPIO_EDGE_ENABLE, 8'h00, 8'hda, 8'hff};

	always #2.5 i_sys_clk = ~i_sys_clk;

	rx_port_interrupt_status i_rx_port_interrupt_status (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_status_one_rd(i_status_one_rd),
		.i_status_two_rd(i_status_two_rd), .i_event_pulse(i_event_pulse), .i_fwd_gpio(i_fwd_gpio),
		.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_port_irq(o_port_irq));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// gpio n: rise enable at bit 2n, fall enable at bit 2n+1
	function automatic logic [3:0] edge_hits(input logic [3:0] prev, input logic [3:0] cur,
		input logic [7:0] en);
		logic [3:0] hit;
		for (int n = 0; n < 4; n++) begin
			hit[n] = (cur[n] & ~prev[n] & en[2*n]) | (~cur[n] & prev[n] & en[2*n+1]);
		end
		return hit;
	endfunction : edge_hits

	// reference state, updated from pre-edge values so set beats clear
	always @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				m_ev[p] = 8'h00;
				m_en[p] = 8'h00;
				m_gen[p] = 8'h00;
				m_gf[p] = 4'h0;
				m_prev[p] = 4'h0;
			end
			m_sel = '0;
			m_rdata = 8'h00;
			m_rv = 1'b0;
			m_irq = '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) m_irq[p] = |(m_ev[p] & m_en[p]);
			m_rv = i_reg_rd;
			if (i_reg_rd) begin
				case (i_reg_addr)
					ADDR_PORT_SELECT:       m_rdata = {6'h00, m_sel};
					ADDR_PORT_EVENT_ENABLE: m_rdata = m_en[m_sel];
					ADDR_PORT_EVENT_STATUS: m_rdata = m_ev[m_sel];
					ADDR_GPIO_STATUS:       m_rdata = {m_gf[m_sel], i_fwd_gpio[m_sel*4 +: 4]};
					default:                m_rdata = 8'h00;
				endcase
			end
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (p == m_sel && i_status_one_rd) m_ev[p] = m_ev[p] & ~STATUS_ONE_MASK;
				if (p == m_sel && i_status_two_rd) m_ev[p] = m_ev[p] & ~STATUS_TWO_MASK;
				m_ev[p] = m_ev[p] | (i_event_pulse[p*8 +: 8] & 8'h77);
				if (p == m_sel && i_reg_rd && i_reg_addr == ADDR_GPIO_STATUS) m_gf[p] = 4'h0;
				m_gf[p] = m_gf[p] | edge_hits(m_prev[p], i_fwd_gpio[p*4 +: 4], m_gen[p]);
				m_prev[p] = i_fwd_gpio[p*4 +: 4];
			end
			if (i_reg_wr && i_reg_addr == ADDR_PORT_EVENT_ENABLE) m_en[m_sel] = i_reg_wdata;
			if (i_reg_wr && i_reg_addr == ADDR_GPIO_EDGE_ENABLE) m_gen[m_sel] = i_reg_wdata;
			if (i_reg_wr && i_reg_addr == ADDR_PORT_SELECT) m_sel = i_reg_wdata[PORT_W-1:0];
		end
	end

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t read data %h expected %h", $time, got, exp);
		end
	endtask : cmp8

	task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t flag set %h expected %h", $time, got, exp);
		end
	endtask : cmp4

	// outputs are registered, so the falling edge sees them settled
	always @(negedge i_sys_clk) begin
		cmp4({3'h0, o_reg_rvalid}, {3'h0, m_rv});
		cmp8(o_reg_rdata, m_rdata);
		cmp4(o_port_irq, m_irq);
	end

	// one cycle of stimulus; every input except i_fwd_gpio and i_reset is set exactly once per falling edge
	task automatic drive(input logic wr, input logic rd, input logic s1, input logic s2,
		input logic [7:0] a, input logic [7:0] d, input logic [31:0] ev);
		i_reg_wr = wr;
		i_reg_rd = rd;
		i_status_one_rd = s1;
		i_status_two_rd = s2;
		i_reg_addr = a;
		i_reg_wdata = d;
		i_event_pulse = ev;
		@(negedge i_sys_clk);
	endtask : drive

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test

	initial begin
		repeat (20) @(negedge i_sys_clk);
		i_reset = 1'b0;
		@(negedge i_sys_clk);
		for (int p = 0; p < NUM_PORTS; p++) begin
			drive(1, 0, 0, 0, ADDR_PORT_SELECT, p[7:0], '0);
			for (int k = 0; k < 8; k++) drive(0, 1, 0, 0, addr_tab[k], 8'h00, '0);
		end
		drive(1, 0, 0, 0, ADDR_PORT_SELECT, 8'h00, '0);
		drive(0, 0, 1, 1, 8'h00, 8'h00, 32'h0000_0077);
		drive(0, 1, 0, 0, ADDR_PORT_EVENT_STATUS, 8'h00, '0);
		// random mix; gpio moves only in cycles without a read, so live bits are unambiguous
		for (int c = 0; c < 4000; c++) begin
			r = rnd();
			case (r[2:0])
				3'd0, 3'd1: drive(1, 0, 0, 0, addr_tab[r[18:16]], (addr_tab[r[18:16]] ==
					ADDR_PORT_SELECT) ? {6'h00, r[9:8]} : r[15:8], rnd() & rnd() & rnd());
				3'd2, 3'd3: drive(0, 1, 0, 0, addr_tab[r[18:16]], 8'h00, rnd() & rnd() & rnd());
				3'd4: drive(0, 0, 1, 0, 8'h00, 8'h00, rnd() & rnd() & rnd());
				3'd5: drive(0, 0, 0, 1, 8'h00, 8'h00, rnd() & rnd() & rnd());
				3'd6: begin
					i_fwd_gpio = r[31:16];
					drive(0, 0, 0, 0, 8'h00, 8'h00, rnd() & rnd() & rnd());
				end
				default: drive(0, 0, 0, 0, 8'h00, 8'h00, '0);
			endcase
		end
		drive(0, 0, 0, 0, 8'h00, 8'h00, '0);
		finish_test();
	end
endmodule : tb

// file: verilog/rx_port_interrupt_status.sv
`timescale 1ns/1ps
// register front end and interrupt output for the per-port status block
module rx_port_interrupt_status
	import rx_port_irq_pkg::*;
(
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_reset,
	input  wire logic                  i_reg_wr,
	input  wire logic                  i_reg_rd,
	input  wire logic [7:0]            i_reg_addr,
	input  wire logic [7:0]            i_reg_wdata,
	input  wire logic                  i_status_one_rd,
	input  wire logic                  i_status_two_rd,
	input  wire logic [NUM_PORTS*8-1:0] i_event_pulse,
	input  wire logic [NUM_PORTS*4-1:0] i_fwd_gpio,
	output logic      [7:0]            o_reg_rdata,
	output logic                       o_reg_rvalid,
	output logic      [NUM_PORTS-1:0]  o_port_irq
);
	logic [PORT_W-1:0]   port_sel_ff;
	logic [NUM_PORTS*8-1:0] enable_ff;
	logic [NUM_PORTS*8-1:0] flags;
	logic [NUM_PORTS*4-1:0] gflags;
	logic [NUM_PORTS*4-1:0] gval;
	logic [7:0]          nxt_rdata;

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			port_sel_ff <= '0;
		end else if (i_reg_wr && i_reg_addr == ADDR_PORT_SELECT) begin
			port_sel_ff <= i_reg_wdata[PORT_W-1:0];
		end
	end

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			logic sel;
			assign sel = (port_sel_ff == PORT_W'(p));
			always_ff @(posedge i_sys_clk or posedge i_reset) begin
				if (i_reset) begin
					enable_ff[p*8 +: 8] <= RESET_VALUE;
				end else if (sel && i_reg_wr && i_reg_addr == ADDR_PORT_EVENT_ENABLE) begin
					enable_ff[p*8 +: 8] <= i_reg_wdata;
				end
			end
			rx_port_slice u_slice (
				.i_sys_clk        (i_sys_clk),
				.i_reset          (i_reset),
				.i_event_pulse    (i_event_pulse[p*8 +: 8]),
				.i_clr_status_one (sel && i_status_one_rd),
				.i_clr_status_two (sel && i_status_two_rd),
				.i_gpio_read      (sel && i_reg_rd && i_reg_addr == ADDR_GPIO_STATUS),
				.i_edge_wr        (sel && i_reg_wr && i_reg_addr == ADDR_GPIO_EDGE_ENABLE),
				.i_wdata          (i_reg_wdata),
				.i_gpio           (i_fwd_gpio[p*4 +: 4]),
				.o_event_flags    (flags[p*8 +: 8]),
				.o_gpio_flags     (gflags[p*4 +: 4]),
				.o_gpio_value     (gval[p*4 +: 4])
			);
			always_ff @(posedge i_sys_clk or posedge i_reset) begin
				if (i_reset) begin
					o_port_irq[p] <= 1'b0;
				end else begin
					// enable gates the latched status only
					o_port_irq[p] <= |(flags[p*8 +: 8] & enable_ff[p*8 +: 8]);
				end
			end
		end
	endgenerate

	// read mux; edge enables are write-only and read zero
	always_comb begin
		nxt_rdata = 8'h00;
		case (i_reg_addr)
			ADDR_PORT_SELECT:       nxt_rdata = {{(8-PORT_W){1'b0}}, port_sel_ff};
			ADDR_PORT_EVENT_ENABLE: nxt_rdata = enable_ff[port_sel_ff*8 +: 8];
			ADDR_PORT_EVENT_STATUS: nxt_rdata = flags[port_sel_ff*8 +: 8];
			ADDR_GPIO_STATUS:       nxt_rdata = {gflags[port_sel_ff*4 +: 4],
				gval[port_sel_ff*4 +: 4]};
			default:                nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= nxt_rdata;
			end
		end
	end

	property p_reserved_zero;
		@(posedge i_sys_clk) disable iff (i_reset)
		(flags & {NUM_PORTS{8'h88}}) == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_lock_set;
		@(posedge i_sys_clk) disable iff (i_reset)
		i_event_pulse[BIT_LOCK] |=> flags[BIT_LOCK];
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock flag lost");

	property p_two_clear;
		@(posedge i_sys_clk) disable iff (i_reset)
		(port_sel_ff == 2'd0 && i_status_two_rd && !i_event_pulse[BIT_LINE_LEN])
		|=> !flags[BIT_LINE_LEN];
	endproperty
	a_two_clear: assert property (p_two_clear) else $error("line length not cleared");

	property p_one_keeps_two;
		@(posedge i_sys_clk) disable iff (i_reset)
		(flags[BIT_BUF_OVF] && !i_status_two_rd) |=> flags[BIT_BUF_OVF];
	endproperty
	a_one_keeps_two: assert property (p_one_keeps_two) else $error("overflow lost");

	property p_irq_gate;
		@(posedge i_sys_clk) disable iff (i_reset)
		o_port_irq[0] |-> $past(|(flags[7:0] & enable_ff[7:0]));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

	property p_rise;
		@(posedge i_sys_clk) disable iff (i_reset)
		(g_port[0].u_slice.edge_enable_ff[0] && $rose(i_fwd_gpio[0])) |=> gflags[0];
	endproperty
	a_rise: assert property (p_rise) else $error("rise missed");

	property p_fall;
		@(posedge i_sys_clk) disable iff (i_reset)
		(g_port[0].u_slice.edge_enable_ff[1] && $fell(i_fwd_gpio[0])) |=> gflags[0];
	endproperty
	a_fall: assert property (p_fall) else $error("fall missed");

	// checked through the read path, where a stale copy would show
	property p_live;
		@(posedge i_sys_clk) disable iff (i_reset)
		(port_sel_ff == 2'd0 && i_reg_rd && i_reg_addr == ADDR_GPIO_STATUS)
		|=> (o_reg_rdata[3:0] == $past(i_fwd_gpio[3:0]));
	endproperty
	a_live: assert property (p_live) else $error("gpio value latched");

	property p_line_len_set;
		@(posedge i_sys_clk) disable iff (i_reset)
		i_event_pulse[BIT_LINE_LEN] |=> flags[BIT_LINE_LEN];
	endproperty
	a_line_len_set: assert property (p_line_len_set) else $error("line length lost");

	property p_line_cnt_set;
		@(posedge i_sys_clk) disable iff (i_reset)
		i_event_pulse[BIT_LINE_CNT] |=> flags[BIT_LINE_CNT];
	endproperty
	a_line_cnt_set: assert property (p_line_cnt_set) else $error("line count lost");

	property p_ovf_set;
		@(posedge i_sys_clk) disable iff (i_reset)
		i_event_pulse[BIT_BUF_OVF] |=> flags[BIT_BUF_OVF];
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow not latched");

	property p_parity_set;
		@(posedge i_sys_clk) disable iff (i_reset)
		i_event_pulse[BIT_PARITY] |=> flags[BIT_PARITY];
	endproperty
	a_parity_set: assert property (p_parity_set) else $error("parity lost");

	property p_valid_set;
		@(posedge i_sys_clk) disable iff (i_reset)
		i_event_pulse[BIT_PORT_VALID] |=> flags[BIT_PORT_VALID];
	endproperty
	a_valid_set: assert property (p_valid_set) else $error("valid change lost");

	property p_cnt_clear;
		@(posedge i_sys_clk) disable iff (i_reset)
		(port_sel_ff == 2'd0 && i_status_two_rd && !i_event_pulse[BIT_LINE_CNT])
		|=> !flags[BIT_LINE_CNT];
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("line count not cleared");

	property p_ovf_clear;
		@(posedge i_sys_clk) disable iff (i_reset)
		(port_sel_ff == 2'd0 && i_status_two_rd && !i_event_pulse[BIT_BUF_OVF])
		|=> !flags[BIT_BUF_OVF];
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared");

	property p_one_clear;
		@(posedge i_sys_clk) disable iff (i_reset)
		(port_sel_ff == 2'd0 && i_status_one_rd && (i_event_pulse[7:0] & STATUS_ONE_MASK) == 8'h00)
		|=> ((flags[7:0] & STATUS_ONE_MASK) == 8'h00);
	endproperty
	a_one_clear: assert property (p_one_clear) else $error("status one not cleared");

	// prev sample, not $past, so a reset mid-run cannot fake an edge
	property p_gpio_clear;
		@(posedge i_sys_clk) disable iff (i_reset)
		(port_sel_ff == 2'd0 && i_reg_rd && i_reg_addr == ADDR_GPIO_STATUS
			&& i_fwd_gpio[3:0] == g_port[0].u_slice.gpio_prev_ff) |=> (gflags[3:0] == 4'h0);
	endproperty
	a_gpio_clear: assert property (p_gpio_clear) else $error("gpio flag not cleared");

	property p_enable_hidden;
		@(posedge i_sys_clk) disable iff (i_reset)
		(i_reg_rd && i_reg_addr == ADDR_GPIO_EDGE_ENABLE) |=> (o_reg_rdata == 8'h00);
	endproperty
	a_enable_hidden: assert property (p_enable_hidden) else $error("edge enable readable");

	property p_status_ro;
		@(posedge i_sys_clk) disable iff (i_reset)
		(i_reg_wr && i_reg_addr == ADDR_PORT_EVENT_STATUS && i_event_pulse[7:0] == 8'h00
			&& !i_status_one_rd && !i_status_two_rd) |=> (flags[7:0] == $past(flags[7:0]));
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status written");

	property p_sel_write;
		@(posedge i_sys_clk) disable iff (i_reset)
		(i_reg_wr && i_reg_addr == ADDR_PORT_SELECT)
		|=> (port_sel_ff == $past(i_reg_wdata[PORT_W-1:0]));
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("port select not taken");

	// a clearing read aimed at another port must leave port 1 alone
	property p_port_apart;
		@(posedge i_sys_clk) disable iff (i_reset)
		(port_sel_ff != 2'd1 && flags[8+BIT_LOCK]) |=> flags[8+BIT_LOCK];
	endproperty
	a_port_apart: assert property (p_port_apart) else $error("wrong port cleared");

	property p_rise3;
		@(posedge i_sys_clk) disable iff (i_reset)
		(g_port[0].u_slice.edge_enable_ff[6] && $rose(i_fwd_gpio[3])) |=> gflags[3];
	endproperty
	a_rise3: assert property (p_rise3) else $error("gpio three rise missed");

	property p_fall3;
		@(posedge i_sys_clk) disable iff (i_reset)
		(g_port[0].u_slice.edge_enable_ff[7] && $fell(i_fwd_gpio[3])) |=> gflags[3];
	endproperty
	a_fall3: assert property (p_fall3) else $error("gpio three fall missed");
endmodule : rx_port_interrupt_status

// file: verilog/rx_port_irq_pkg.sv
// constants for the per-port receiver interrupt status block
package rx_port_irq_pkg;
	localparam int          NUM_PORTS              = 4;
	localparam int          PORT_W                 = 2;
	localparam int          NUM_GPIO               = 4;
	localparam logic [7:0]  ADDR_PORT_SELECT       = 8'h4c;
	localparam logic [7:0]  ADDR_PORT_EVENT_ENABLE = 8'hd9;
	localparam logic [7:0]  ADDR_PORT_EVENT_STATUS = 8'hdb;
	localparam logic [7:0]  ADDR_GPIO_STATUS       = 8'hdc;
	localparam logic [7:0]  ADDR_GPIO_EDGE_ENABLE  = 8'hdd;
	localparam logic [7:0]  RESET_VALUE            = 8'h00;
	localparam int          BIT_LINE_LEN           = 6;
	localparam int          BIT_LINE_CNT           = 5;
	localparam int          BIT_BUF_OVF            = 4;
	localparam int          BIT_PARITY             = 2;
	localparam int          BIT_PORT_VALID         = 1;
	localparam int          BIT_LOCK               = 0;
	localparam logic [7:0]  STATUS_TWO_MASK        = 8'h70;
	localparam logic [7:0]  STATUS_ONE_MASK        = 8'h07;
	localparam int          GPIO_FLAG_LSB          = 4;
endpackage : rx_port_irq_pkg

// file: verilog/rx_port_slice.sv
`timescale 1ns/1ps
// one receive port's event flags, gpio edge flags and edge enables
module rx_port_slice
	import rx_port_irq_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	input  wire logic [7:0] i_event_pulse,
	input  wire logic       i_clr_status_one,
	input  wire logic       i_clr_status_two,
	input  wire logic       i_gpio_read,
	input  wire logic       i_edge_wr,
	input  wire logic [7:0] i_wdata,
	input  wire logic [3:0] i_gpio,
	output logic      [7:0] o_event_flags,
	output logic      [3:0] o_gpio_flags,
	output logic      [3:0] o_gpio_value
);
	logic [7:0] edge_enable_ff;
	logic [3:0] gpio_prev_ff;
	logic [3:0] gpio_hit;
	logic [7:0] clr_mask;

	assign clr_mask = (i_clr_status_one ? STATUS_ONE_MASK : 8'h00)
		| (i_clr_status_two ? STATUS_TWO_MASK : 8'h00);

	// reserved bits 7 and 3 never latch
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_event_flags <= RESET_VALUE;
		end else begin
			// set wins over clearing read
			o_event_flags <= ((o_event_flags & ~clr_mask) | i_event_pulse)
				& (STATUS_ONE_MASK | STATUS_TWO_MASK);
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			edge_enable_ff <= RESET_VALUE;
		end else if (i_edge_wr) begin
			edge_enable_ff <= i_wdata;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			gpio_prev_ff <= 4'h0;
		end else begin
			gpio_prev_ff <= i_gpio;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_GPIO; g++) begin : g_edge
			assign gpio_hit[g] = (edge_enable_ff[2*g+1] & gpio_prev_ff[g] & ~i_gpio[g])
				| (edge_enable_ff[2*g] & ~gpio_prev_ff[g] & i_gpio[g]);
		end
	endgenerate

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_gpio_flags <= 4'h0;
		end else begin
			o_gpio_flags <= (i_gpio_read ? 4'h0 : o_gpio_flags) | gpio_hit;
		end
	end

	assign o_gpio_value = i_gpio;
endmodule : rx_port_slice
